// ==== rrs_fifo2.sv ====
`timescale 1ns/1ps
// ****************************************************************
// two entry buffer, full throughput with registered data
// ****************************************************************
module rrs_fifo2 #(
  parameter int WIDTH = 9
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic [1:0]            cnt;
    logic                  rd;
    logic                  wr;
  } rrs_fifo_s;

  rrs_fifo_s r;
  rrs_fifo_s next_r;
  logic      push;
  logic      pop;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("rrs_fifo2: WIDTH must be at least one");
  end

  // full and empty come straight from the count
  assign in_ready  = (r.cnt != 2'h2);
  assign out_valid = (r.cnt != 2'h0);
  assign out_data  = r.mem[r.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer and count update
  always_comb
  begin
    next_r = r;
    if (push)
    begin
      next_r.mem[r.wr] = in_data;
      next_r.wr        = ~r.wr;
    end
    if (pop)
      next_r.rd = ~r.rd;
    if (push && !pop)
      next_r.cnt = r.cnt + 2'h1;
    else if (pop && !push)
      next_r.cnt = r.cnt - 2'h1;
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (srst)
      r <= '0;
    else
      r <= next_r;
  end
endmodule

// ==== rrs_link_if.sv ====
`timescale 1ns/1ps
// ****************************************************************
// byte stream link, frame cut by last, crc handled by companion
// ****************************************************************
interface rrs_link_if;
  logic       req_valid;
  logic       req_ready;
  logic [7:0] req_data;
  logic       req_last;
  logic       req_crc_err;
  logic       rsp_valid;
  logic       rsp_ready;
  logic [7:0] rsp_data;
  logic       rsp_last;
  modport master (output req_valid, req_data, req_last, req_crc_err, rsp_ready,
                  input  req_ready, rsp_valid, rsp_data, rsp_last);
  modport slave  (input  req_valid, req_data, req_last, req_crc_err, rsp_ready,
                  output req_ready, rsp_valid, rsp_data, rsp_last);
endinterface

// ==== rrs_link_sva.sv ====
`timescale 1ns/1ps
// ****************************************************************
// link checker between the two ends
// ****************************************************************
module rrs_link_sva (
  // clock and reset
  input wire logic       clk,
  input wire logic       srst,
  // request stream
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic [7:0] req_data,
  input wire logic       req_last,
  input wire logic       req_crc_err,
  // answer stream
  input wire logic       rsp_valid,
  input wire logic       rsp_ready,
  input wire logic [7:0] rsp_data,
  input wire logic       rsp_last
);
  logic [7:0] node_q;
  logic [7:0] fc_q;
  logic [1:0] req_n;
  logic [1:0] rsp_n;
  // node and function of each frame; answer position saturates so stale answers are not judged
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      req_n  <= 2'h0;
      rsp_n  <= 2'h3;
      node_q <= 8'h00;
      fc_q   <= 8'h00;
    end
    else
    begin
      if (req_valid && req_ready)
      begin
        req_n <= req_last ? 2'h0 : ((req_n == 2'h2) ? 2'h2 : req_n + 2'h1);
        if (req_n == 2'h0) node_q <= req_data;
        if (req_n == 2'h1) fc_q <= req_data;
      end
      if (req_valid && req_ready && req_last) rsp_n <= 2'h0;
      else if (rsp_valid && rsp_ready && rsp_n != 2'h3) rsp_n <= rsp_n + 2'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence take_last;
    req_valid && req_ready && req_last;
  endsequence
  sequence stays_quiet;
    !rsp_valid [*8];
  endsequence
  a_req_held: assert property (req_valid && !req_ready |=> req_valid && $stable(req_data) && $stable(req_last))
    else $error("request byte changed before it was taken");
  a_rsp_held: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_last))
    else $error("answer byte changed before it was taken");
  a_check_blocks: assert property (take_last |=> !req_ready)
    else $error("slave kept taking bytes after a frame end");
  a_ready_returns: assert property (take_last |-> ##[2:200] req_ready)
    else $error("slave did not return to frame reception");
  a_bcast_quiet: assert property (take_last and node_q == rrs_pkg::NODE_BCAST |=> stays_quiet)
    else $error("broadcast frame was answered");
  a_crc_quiet: assert property (take_last and req_crc_err |=> stays_quiet)
    else $error("frame with bad check was answered");
  a_answer_node: assert property (rsp_valid && rsp_n == 2'h0 |-> rsp_data == node_q)
    else $error("answer does not start with the own node");
  a_answer_func: assert property (rsp_valid && rsp_n == 2'h1 |-> rsp_data[6:0] == fc_q[6:0])
    else $error("answer function differs from request");
endmodule

// ==== rrs_master.sv ====
`timescale 1ns/1ps
// ****************************************************************
// request builder of the remote master
// ****************************************************************
module rrs_master #(
  parameter int MAX_REGS    = rrs_pkg::MAX_REGS,
  parameter int TIMEOUT_CYC = rrs_pkg::RSP_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    srst,
  // link to the slave
  rrs_link_if.master                   lnk,
  // command port
  input  wire logic                    cmd_valid,
  output logic                         cmd_ready,
  input  wire logic [7:0]              cmd_node,
  input  wire logic [7:0]              cmd_fc,
  input  wire logic [15:0]             cmd_rreg,
  input  wire logic [15:0]             cmd_rcount,
  input  wire logic [15:0]             cmd_wreg,
  input  wire logic [15:0]             cmd_wcount,
  input  wire logic [MAX_REGS*16-1:0]  cmd_wdata,
  input  wire logic                    cmd_crc_err,
  // answer bytes and timeout
  output logic                         rsp_valid,
  output logic [7:0]                   rsp_data,
  output logic                         rsp_last,
  output logic                         rsp_timeout
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SEND = 3'h2,
    ST_RECV = 3'h4
  } rrs_mstate_e;

  typedef struct packed {
    rrs_mstate_e           st;
    logic [10:0][7:0]      h;
    logic [6:0]            hl;
    logic [6:0]            tlen;
    logic [MAX_REGS*16-1:0] wdata;
    logic [6:0]            j;
    logic                  crc_err;
    logic [31:0]           tmr;
    logic                  rv;
    logic [7:0]            rd;
    logic                  rl;
    logic                  to;
  } rrs_master_s;

  rrs_master_s r;
  rrs_master_s next_r;
  logic [15:0] radr;
  logic [15:0] wadr;
  logic [6:0]  m;
  logic [15:0] w;
  logic        f_valid;
  logic        f_ready;
  logic [9:0]  f_data;

  // the master may build requests past the slave limit, so that a drop can be provoked
  if (MAX_REGS < 1 || MAX_REGS > 32 || TIMEOUT_CYC < 1)
  begin : g_bad_par
    $error("rrs_master: MAX_REGS must lie in 1..32 and TIMEOUT_CYC above zero");
  end

  // logical number to frame address, type bits ride along
  assign radr = cmd_rreg - rrs_pkg::REG_BASE - 16'h1;
  assign wadr = cmd_wreg - rrs_pkg::REG_BASE - 16'h1;
  assign m    = r.j - r.hl;
  assign w    = r.wdata[16*m[6:1] +: 16];

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb
  begin
    next_r    = r;
    next_r.rv = 1'b0;
    next_r.to = 1'b0;
    f_valid   = 1'b0;
    f_data    = {r.crc_err, (r.j == r.tlen - 7'h1),
                 (r.j < r.hl) ? r.h[r.j[3:0]] : (m[0] ? w[7:0] : w[15:8])};
    unique case (r.st)
      // latch the command and lay out the header
      ST_IDLE:
      begin
        if (cmd_valid)
        begin
          next_r.h       = '0;
          next_r.h[0]    = cmd_node;
          next_r.h[1]    = cmd_fc;
          next_r.wdata   = cmd_wdata;
          next_r.crc_err = cmd_crc_err;
          next_r.j       = 7'h0;
          next_r.st      = ST_SEND;
          {next_r.h[2], next_r.h[3]} = (cmd_fc == rrs_pkg::FC_READ || cmd_fc == rrs_pkg::FC_RDWR) ? radr : wadr;
          {next_r.h[4], next_r.h[5]} = (cmd_fc == rrs_pkg::FC_WRITE1) ? cmd_wdata[15:0]
                                     : (cmd_fc == rrs_pkg::FC_WRITEN) ? cmd_wcount : cmd_rcount;
          next_r.hl      = 7'h6;
          next_r.tlen    = 7'h6;
          if (cmd_fc == rrs_pkg::FC_WRITEN)
          begin
            next_r.h[6] = {1'b0, cmd_wcount[5:0], 1'b0};
            next_r.hl   = 7'h7;
            next_r.tlen = 7'h7 + {cmd_wcount[5:0], 1'b0};
          end
          else if (cmd_fc == rrs_pkg::FC_RDWR)
          begin
            {next_r.h[6], next_r.h[7]} = wadr;
            {next_r.h[8], next_r.h[9]} = cmd_wcount;
            next_r.h[10] = {1'b0, cmd_wcount[5:0], 1'b0};
            next_r.hl    = 7'hb;
            next_r.tlen  = 7'hb + {cmd_wcount[5:0], 1'b0};
          end
        end
      end
      // walk the frame out through the buffer
      ST_SEND:
      begin
        f_valid = 1'b1;
        if (f_ready)
        begin
          next_r.j = r.j + 7'h1;
          if (r.j == r.tlen - 7'h1)
          begin
            next_r.tmr = 32'h0;
            next_r.st  = (r.h[0] == rrs_pkg::NODE_BCAST) ? ST_IDLE : ST_RECV;
          end
        end
      end
      // pass answer bytes on; give up after the timeout
      ST_RECV:
      begin
        next_r.tmr = r.tmr + 32'h1;
        if (lnk.rsp_valid)
        begin
          next_r.rv = 1'b1;
          next_r.rd = lnk.rsp_data;
          next_r.rl = lnk.rsp_last;
          if (lnk.rsp_last)
            next_r.st = ST_IDLE;
        end
        else if (r.tmr == 32'(TIMEOUT_CYC - 1))
        begin
          next_r.to = 1'b1;
          next_r.st = ST_IDLE;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      r    <= '0;
      r.st <= ST_IDLE;
    end
    else
      r <= next_r;
  end

  // late answer bytes are drained and dropped in idle; they are held while a request is sent
  assign cmd_ready     = (r.st == ST_IDLE);
  assign lnk.rsp_ready = (r.st != ST_SEND);
  assign rsp_valid     = r.rv;
  assign rsp_data      = r.rd;
  assign rsp_last      = r.rl;
  assign rsp_timeout   = r.to;

  // request buffer, stalled by the slave ready
  rrs_fifo2 #(
    .WIDTH (10)
  ) u_req_buf (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (f_valid),
    .in_ready  (f_ready),
    .in_data   (f_data),
    .out_valid (lnk.req_valid),
    .out_ready (lnk.req_ready),
    .out_data  ({lnk.req_crc_err, lnk.req_last, lnk.req_data})
  );
endmodule

// ==== rrs_pkg.sv ====
// ****************************************************************
// shared constants of the register slave link
// ****************************************************************
package rrs_pkg;
  // function codes
  localparam logic [7:0] FC_READ    = 8'h03;
  localparam logic [7:0] FC_WRITE1  = 8'h06;
  localparam logic [7:0] FC_WRITEN  = 8'h10;
  localparam logic [7:0] FC_RDWR    = 8'h17;
  // exception answers and broadcast node
  localparam logic [7:0] EXC_FLAG   = 8'h80;
  localparam logic [7:0] EXC_FN     = 8'h01;
  localparam logic [7:0] EXC_ADDR   = 8'h02;
  localparam logic [7:0] NODE_BCAST = 8'h00;
  // access type field, bits 15-14 of a register address
  localparam logic [1:0] ACC_16     = 2'h0;
  localparam logic [1:0] ACC_32     = 2'h1;
  // logical register numbering offset
  localparam logic [15:0] REG_BASE  = 16'h9c40;
  // limits and sizes
  localparam int MAX_REGS           = 20;
  localparam int RX_DEPTH           = 64;
  // answer timeout at the master
  localparam int CLK_MHZ            = 25;
  localparam int RSP_TIMEOUT_US     = 1000;
  localparam int RSP_TIMEOUT_CYC    = RSP_TIMEOUT_US * CLK_MHZ;
endpackage

// ==== rrs_slave.sv ====
`timescale 1ns/1ps
// ****************************************************************
// register slave: frame filter, decoder, writer and answer builder
// ****************************************************************
// Overview of operation
// - slave end answers remote register requests
// - accept function codes 3, 6, 16, 23
// - at most twenty registers per transaction
// - parameter index is menu*100 plus parameter
// - address bits 15-14 select access width
// - 16-bit read of wide parameter gives low half
// - frame address is logical number minus one
// - act only on own or broadcast node
// - read request is eight bytes with crc
// - read answer: node, fc, count, data
// - too many read registers gives exception 2
// - single write stores, then echoes request
// - single write to wide parameter: 16 bits
// - multiple write carries count, bytes, data
// - oversize multiple write dropped without answer
// - multiple write answer echoes start, count
// - combined request carries read, write, data
// - combined answer: node, fc, count, data
module rrs_slave #(
  parameter int MAX_REGS = rrs_pkg::MAX_REGS
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // link to the remote master
  rrs_link_if.slave        lnk,
  // own node address
  input  wire logic [7:0]  node_addr,
  // parameter store write port
  output logic             par_wr,
  output logic [13:0]      par_wr_idx,
  output logic [31:0]      par_wr_data,
  output logic             par_wr_wide,
  // parameter store read port, answered in the same cycle
  output logic [13:0]      par_rd_idx,
  input  wire logic [31:0] par_rd_data,
  // status
  output logic             frame_drop
);
  typedef enum logic [3:0] {
    ST_RX    = 4'h1,
    ST_CHECK = 4'h2,
    ST_WRITE = 4'h4,
    ST_SEND  = 4'h8
  } rrs_state_e;

  typedef struct packed {
    rrs_state_e                        st;
    logic [rrs_pkg::RX_DEPTH-1:0][7:0] rx;
    logic [6:0]                        rxn;
    logic                              ovf;
    logic                              crc_err;
    logic [7:0]                        exc;
    logic [5:0]                        k;
    logic [15:0]                       hi;
    logic [6:0]                        j;
    logic                              wr;
    logic [13:0]                       widx;
    logic [31:0]                       wdata;
    logic                              wide;
    logic                              drop;
  } rrs_slave_s;

  rrs_slave_s  r;
  rrs_slave_s  next_r;
  logic [7:0]  fc;
  logic [5:0]  off;
  logic [5:0]  db;
  logic [15:0] radr;
  logic [15:0] rcnt;
  logic [15:0] wadr;
  logic [15:0] wcnt;
  logic [13:0] rbase;
  logic [13:0] wbase;
  logic        rok;
  logic        wok;
  logic        wide_w;
  logic        bcast;
  logic [15:0] d;
  logic [6:0]  m;
  logic [5:0]  rk;
  logic [15:0] rword;
  logic [6:0]  tlen;
  logic [7:0]  tbyte;
  logic        f_valid;
  logic        f_ready;
  logic [8:0]  f_data;

  if (MAX_REGS < 1 || MAX_REGS > 20)
  begin : g_bad_max
    $error("rrs_slave: MAX_REGS must lie in 1..20");
  end

  // ****************************************************************
  // field decode of the stored frame
  // ****************************************************************
  // combined request shifts its write fields by four bytes
  assign fc     = r.rx[1];
  assign off    = (fc == rrs_pkg::FC_RDWR) ? 6'h4 : 6'h0;
  assign radr   = {r.rx[2], r.rx[3]};
  assign rcnt   = {r.rx[4], r.rx[5]};
  assign wadr   = {r.rx[6'h2 + off], r.rx[6'h3 + off]};
  assign wcnt   = (fc == rrs_pkg::FC_WRITE1) ? 16'h1 : {r.rx[6'h4 + off], r.rx[6'h5 + off]};
  assign db     = (fc == rrs_pkg::FC_WRITE1) ? 6'h4 : 6'h7 + off;
  assign rbase  = radr[13:0] + 14'h1;
  assign wbase  = wadr[13:0] + 14'h1;
  assign bcast  = (r.rx[0] == rrs_pkg::NODE_BCAST);
  // a single write never pairs words, so it stays 16 bits wide
  assign wide_w = (wadr[15:14] == rrs_pkg::ACC_32) && (fc != rrs_pkg::FC_WRITE1);
  // reserved access types fail the range checks
  assign rok    = (rcnt != 16'h0) && (rcnt <= 16'(MAX_REGS)) && !radr[15];
  assign wok    = (wcnt != 16'h0) && (wcnt <= 16'(MAX_REGS)) && !wadr[15]
                  && ((fc == rrs_pkg::FC_WRITE1) || (r.rx[6'h6 + off] == {1'b0, wcnt[5:0], 1'b0}))
                  && (r.rxn == {1'b0, db} + {wcnt[5:0], 1'b0});
  assign d      = {r.rx[db + {r.k[4:0], 1'b0}], r.rx[db + {r.k[4:0], 1'b0} + 6'h1]};

  // ****************************************************************
  // answer byte selection
  // ****************************************************************
  // wide reads take two registers per parameter, high word first
  assign m          = r.j - 7'h3;
  assign rk         = m[6:1];
  assign par_rd_idx = (radr[15:14] == rrs_pkg::ACC_32) ? rbase + 14'(rk[5:1]) : rbase + 14'(rk);
  assign rword      = ((radr[15:14] == rrs_pkg::ACC_32) && !rk[0]) ? par_rd_data[31:16]
                                                                   : par_rd_data[15:0];
  assign tlen       = (r.exc != 8'h0) ? 7'h3
                    : ((fc == rrs_pkg::FC_READ) || (fc == rrs_pkg::FC_RDWR)) ? 7'h3 + {rcnt[5:0], 1'b0}
                    : 7'h6;

  // exception, data read or echo of the request head
  always_comb
  begin
    if (r.exc != 8'h0)
      tbyte = (r.j == 7'h0) ? r.rx[0] : (r.j == 7'h1) ? (fc | rrs_pkg::EXC_FLAG) : r.exc;
    else if ((fc == rrs_pkg::FC_READ) || (fc == rrs_pkg::FC_RDWR))
    begin
      if (r.j < 7'h2)
        tbyte = r.rx[r.j[5:0]];
      else if (r.j == 7'h2)
        tbyte = {1'b0, rcnt[5:0], 1'b0};
      else
        tbyte = m[0] ? rword[7:0] : rword[15:8];
    end
    else
      tbyte = r.rx[r.j[5:0]];
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb
  begin
    next_r      = r;
    next_r.wr   = 1'b0;
    next_r.drop = 1'b0;
    f_valid     = 1'b0;
    f_data      = {(r.j == tlen - 7'h1), tbyte};
    unique case (r.st)
      // collect bytes; overlong frames are marked for dropping
      ST_RX:
      begin
        if (lnk.req_valid)
        begin
          if (!r.rxn[6])
          begin
            next_r.rx[r.rxn[5:0]] = lnk.req_data;
            next_r.rxn            = r.rxn + 7'h1;
          end
          else
            next_r.ovf = 1'b1;
          if (lnk.req_last)
          begin
            next_r.crc_err = lnk.req_crc_err;
            next_r.st      = ST_CHECK;
          end
        end
      end
      // decide execute, exception or silent drop
      ST_CHECK:
      begin
        next_r.exc = 8'h0;
        next_r.k   = 6'h0;
        next_r.j   = 7'h0;
        next_r.rxn = 7'h0;
        next_r.ovf = 1'b0;
        next_r.st  = ST_RX;
        if (!r.crc_err && !r.ovf && (r.rxn >= 7'h4)
            && ((r.rx[0] == node_addr) || bcast))
        begin
          case (fc)
            rrs_pkg::FC_READ:
            begin
              if (r.rxn == 7'h6)
              begin
                next_r.st = ST_SEND;
                if (!rok)
                  next_r.exc = rrs_pkg::EXC_ADDR;
              end
            end
            rrs_pkg::FC_WRITE1, rrs_pkg::FC_WRITEN:
            begin
              if (wok)
                next_r.st = ST_WRITE;
            end
            rrs_pkg::FC_RDWR:
            begin
              if (wok && rok)
                next_r.st = ST_WRITE;
              else if (wok)
              begin
                next_r.st  = ST_SEND;
                next_r.exc = rrs_pkg::EXC_ADDR;
              end
            end
            default:
            begin
              next_r.st  = ST_SEND;
              next_r.exc = rrs_pkg::EXC_FN;
            end
          endcase
          if (bcast && (next_r.st == ST_SEND))
            next_r.st = ST_RX;
        end
        next_r.drop = (next_r.st == ST_RX);
      end
      // one register per cycle; wide mode stores the high word first
      ST_WRITE:
      begin
        if (wide_w && !r.k[0])
          next_r.hi = d;
        else
        begin
          next_r.wr    = 1'b1;
          next_r.widx  = wide_w ? wbase + 14'(r.k[5:1]) : wbase + 14'(r.k);
          next_r.wdata = wide_w ? {r.hi, d} : {16'h0, d};
          next_r.wide  = wide_w;
        end
        next_r.k = r.k + 6'h1;
        if (r.k == wcnt[5:0] - 6'h1)
          next_r.st = bcast ? ST_RX : ST_SEND;
      end
      // the buffer ready stalls this walk
      ST_SEND:
      begin
        f_valid = 1'b1;
        if (f_ready)
        begin
          next_r.j = r.j + 7'h1;
          if (r.j == tlen - 7'h1)
            next_r.st = ST_RX;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      r    <= '0;
      r.st <= ST_RX;
    end
    else
      r <= next_r;
  end

  // ****************************************************************
  // outputs and answer buffer
  // ****************************************************************
  assign lnk.req_ready = (r.st == ST_RX);
  assign par_wr        = r.wr;
  assign par_wr_idx    = r.widx;
  assign par_wr_data   = r.wdata;
  assign par_wr_wide   = r.wide;
  assign frame_drop    = r.drop;

  // a stalled master loses no answer byte
  rrs_fifo2 #(
    .WIDTH (9)
  ) u_tx_buf (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (f_valid),
    .in_ready  (f_ready),
    .in_data   (f_data),
    .out_valid (lnk.rsp_valid),
    .out_ready (lnk.rsp_ready),
    .out_data  ({lnk.rsp_last, lnk.rsp_data})
  );
endmodule

// ==== tb_rtu_register_slave.sv ====
`timescale 1ns/1ps
// ****************************************************************
// bench: master end talks to slave end across the link
// ****************************************************************
module tb_rtu_register_slave;
  logic         clk = 1'b0;
  logic         srst = 1'b1;
  logic         cmd_valid = 1'b0;
  logic         cmd_crc_err = 1'b0;
  logic [7:0]   cmd_node = 8'h00, cmd_fc = 8'h00;
  logic [15:0]  cmd_rreg = 16'h0000, cmd_rcount = 16'h0000, cmd_wreg = 16'h0000, cmd_wcount = 16'h0000;
  logic [383:0] cmd_wdata = '0, wd;
  logic         cmd_ready, rsp_valid, rsp_last, rsp_timeout, par_wr, par_wr_wide, frame_drop;
  logic [7:0]   rsp_data;
  logic [13:0]  par_wr_idx, par_rd_idx;
  logic [31:0]  par_wr_data, par_rd_data;
  logic         done = 1'b0, to_seen = 1'b0, drop_seen = 1'b0;
  logic [7:0]   got[$], exp[$];
  logic [46:0]  wr[$], ew[$];
  int           n_errors = 0, samples_checked = 0, cyc = 0;
  always #20 clk = ~clk;
  // parameter store: high half marked so a wide value is told from its low half
  assign par_rd_data = {8'hc3, 10'h000, par_rd_idx};
  rrs_link_if rrs_link_if_i ();
  rrs_master #(.MAX_REGS(24), .TIMEOUT_CYC(50)) rrs_master_i (.clk(clk), .srst(srst), .lnk(rrs_link_if_i),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_node(cmd_node), .cmd_fc(cmd_fc), .cmd_rreg(cmd_rreg),
    .cmd_rcount(cmd_rcount), .cmd_wreg(cmd_wreg), .cmd_wcount(cmd_wcount), .cmd_wdata(cmd_wdata),
    .cmd_crc_err(cmd_crc_err), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last),
    .rsp_timeout(rsp_timeout));
  rrs_slave rrs_slave_i (.clk(clk), .srst(srst), .lnk(rrs_link_if_i), .node_addr(8'h05), .par_wr(par_wr),
    .par_wr_idx(par_wr_idx), .par_wr_data(par_wr_data), .par_wr_wide(par_wr_wide), .par_rd_idx(par_rd_idx),
    .par_rd_data(par_rd_data), .frame_drop(frame_drop));
  rrs_link_sva rrs_link_sva_i (.clk(clk), .srst(srst), .req_valid(rrs_link_if_i.req_valid),
    .req_ready(rrs_link_if_i.req_ready), .req_data(rrs_link_if_i.req_data), .req_last(rrs_link_if_i.req_last),
    .req_crc_err(rrs_link_if_i.req_crc_err), .rsp_valid(rrs_link_if_i.rsp_valid),
    .rsp_ready(rrs_link_if_i.rsp_ready), .rsp_data(rrs_link_if_i.rsp_data), .rsp_last(rrs_link_if_i.rsp_last));
  // collect answers, writes and events; cycle ceiling cuts a hang short
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (rsp_valid) got.push_back(rsp_data);
    if (par_wr) wr.push_back({par_wr_wide, par_wr_idx, par_wr_data});
    if ((rsp_valid && rsp_last) || rsp_timeout) done = 1'b1;
    if (rsp_timeout) to_seen = 1'b1;
    if (frame_drop) drop_seen = 1'b1;
    if (cyc == 10000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input string name, input logic [46:0] e, input logic [46:0] g);
    samples_checked++;
    if (e !== g)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask
  // one request through the master, then answer bytes and store writes against the expected queues
  task automatic run(input logic [7:0] node, fc, input logic [15:0] rreg, rcnt, wreg, wcnt, input logic crc, quiet);
    int n;
    got.delete();
    wr.delete();
    done = 1'b0;
    to_seen = 1'b0;
    drop_seen = 1'b0;
    for (n = 0; n < 100 && cmd_ready !== 1'b1; n++) @(negedge clk);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_node <= node;
    cmd_fc <= fc;
    cmd_rreg <= rreg;
    cmd_rcount <= rcnt;
    cmd_wreg <= wreg;
    cmd_wcount <= wcnt;
    cmd_wdata <= wd;
    cmd_crc_err <= crc;
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (n = 0; n < 200 && !done; n++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk("timeout", {46'h0, quiet && node != 8'h00}, {46'h0, to_seen});
    chk("frame_drop", {46'h0, quiet && node != 8'h00}, {46'h0, drop_seen});
    chk("rsp_len", exp.size(), got.size());
    foreach (exp[i]) chk("rsp_byte", exp[i], (i < got.size()) ? got[i] : 8'hxx);
    chk("wr_len", ew.size(), wr.size());
    foreach (ew[i]) chk("wr", ew[i], (i < wr.size()) ? wr[i] : 47'hx);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial
  begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    wd = '0;
    wd[15:0] = 16'h1234;
    exp = '{8'h05, 8'h06, 8'h00, 8'h78, 8'h12, 8'h34};
    ew = '{{1'b0, 14'd121, 32'h1234}};
    run(8'h05, rrs_pkg::FC_WRITE1, 16'd0, 16'd0, 16'd40121, 16'd1, 1'b0, 1'b0);
    wd[15:0] = 16'habcd;
    exp = '{8'h05, 8'h06, 8'h5b, 8'h58, 8'hab, 8'hcd};
    ew = '{{1'b0, 14'd7001, 32'habcd}};
    run(8'h05, rrs_pkg::FC_WRITE1, 16'd0, 16'd0, 16'd63385, 16'd1, 1'b0, 1'b0);
    ew = '{};
    exp = '{8'h05, 8'h03, 8'h04, 8'h00, 8'h79, 8'h00, 8'h7a};
    run(8'h05, rrs_pkg::FC_READ, 16'd40121, 16'd2, 16'd0, 16'd0, 1'b0, 1'b0);
    exp = '{8'h05, 8'h03, 8'h04, 8'hc3, 8'h00, 8'h1b, 8'h59};
    run(8'h05, rrs_pkg::FC_READ, 16'd63385, 16'd2, 16'd0, 16'd0, 1'b0, 1'b0);
    exp = '{8'h05, 8'h03, 8'h28};
    for (int k = 121; k < 141; k++) exp = {exp, 8'h00, 8'(k)};
    run(8'h05, rrs_pkg::FC_READ, 16'd40121, 16'd20, 16'd0, 16'd0, 1'b0, 1'b0);
    exp = '{8'h05, 8'h83, 8'h02};
    run(8'h05, rrs_pkg::FC_READ, 16'd40121, 16'd21, 16'd0, 16'd0, 1'b0, 1'b0);
    exp = '{8'h05, 8'h84, 8'h01};
    run(8'h05, 8'h04, 16'd40121, 16'd1, 16'd0, 16'd0, 1'b0, 1'b0);
    wd[47:0] = 48'h0003_0002_0001;
    exp = '{8'h05, 8'h10, 8'h00, 8'hc8, 8'h00, 8'h03};
    ew = '{{1'b0, 14'd201, 32'h0001}, {1'b0, 14'd202, 32'h0002}, {1'b0, 14'd203, 32'h0003}};
    run(8'h05, rrs_pkg::FC_WRITEN, 16'd0, 16'd0, 16'd40201, 16'd3, 1'b0, 1'b0);
    wd[31:0] = 32'hcdef_89ab;
    exp = '{8'h05, 8'h10, 8'h5b, 8'h58, 8'h00, 8'h02};
    ew = '{{1'b1, 14'd7001, 32'h89ab_cdef}};
    run(8'h05, rrs_pkg::FC_WRITEN, 16'd0, 16'd0, 16'd63385, 16'd2, 1'b0, 1'b0);
    exp = '{};
    ew = '{};
    run(8'h05, rrs_pkg::FC_WRITEN, 16'd0, 16'd0, 16'd40201, 16'd21, 1'b0, 1'b1);
    wd[15:0] = 16'h5555;
    exp = '{8'h05, 8'h17, 8'h02, 8'h00, 8'h79};
    ew = '{{1'b0, 14'd301, 32'h5555}};
    run(8'h05, rrs_pkg::FC_RDWR, 16'd40121, 16'd1, 16'd40301, 16'd1, 1'b0, 1'b0);
    exp = '{};
    run(8'h00, rrs_pkg::FC_WRITE1, 16'd0, 16'd0, 16'd40301, 16'd1, 1'b0, 1'b1);
    ew = '{};
    run(8'h09, rrs_pkg::FC_READ, 16'd40121, 16'd1, 16'd0, 16'd0, 1'b0, 1'b1);
    run(8'h05, rrs_pkg::FC_WRITE1, 16'd0, 16'd0, 16'd40301, 16'd1, 1'b1, 1'b1);
    tally_and_finish();
  end
endmodule
